/* rtl/armap_pkg.sv */
// Purpose: Shared constants for the receive slot mapper
// Assumes: Byte-wide register port, 32-bit slots on the serial link
// Notes:   Every offset, field position and reset value lives here

package armap_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_SEL  = 8'h27;
  localparam logic [7:0] ADDR_CH1_CFG  = 8'h28;
  localparam logic [7:0] ADDR_CH2_CFG  = 8'h29;

  localparam logic [7:0] RST_PIN_SEL   = 8'h00;
  localparam logic [7:0] RST_CH1_CFG   = 8'h20;
  localparam logic [7:0] RST_CH2_CFG   = 8'h21;

  // Channel config fields: bit 5 enable, bits 4..0 slot, bits 7..6 reserved
  localparam int         CFG_EN_BIT    = 5;
  localparam int         CFG_SLOT_MSB  = 4;
  localparam int         CFG_W         = 6;
  localparam logic [7:0] CFG_RSVD_ZERO = 8'h00;

  // ---------------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------------
  localparam int         NUM_CH        = 2;
  localparam int         PIN_SEL_W     = 8;
  localparam int         WORD_W        = 32;
  localparam int         POS_W         = 10;
  localparam logic [4:0] LAST_BIT      = 5'h1F;
  localparam logic [POS_W-1:0] POS_LAST = 10'h3FF;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         FIFO_W        = WORD_W + 1;

  // Serial frame formats
  typedef enum logic [1:0] {
    FMT_TDM       = 2'b00,
    FMT_I2S       = 2'b01,
    FMT_LEFT_JUST = 2'b11
  } armap_fmt_e;

  // Frame tracking on the bit clock
  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_RUN  = 1'b1
  } armap_rx_e;

endpackage

/* rtl/armap_mem.sv */
// Purpose: Dual-clock storage for the sample FIFO
// Assumes: Write and read ports on unrelated clocks
// Notes:   Read data come out of a register

`timescale 1ns/100ps

module armap_mem #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             wrClk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             rdClk,
  input  wire logic             rdEn,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData_q
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge wrClk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge rdClk) begin
    if (rdEn) begin
      rdData_q <= store[rdAddr];
    end
  end

endmodule // armap_mem

/* rtl/armap_fifo.sv */
// Purpose: Asynchronous FIFO from the bit clock to the system clock
// Assumes: Synchronous active-low resets, one per side
// Notes:   Gray pointers cross through two flip-flops each

`timescale 1ns/100ps

module armap_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input  wire logic             wrClk,
  input  wire logic             wrRstn,
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  input  wire logic             rdClk,
  input  wire logic             rdRstn,
  output logic                  rdValid,
  output logic      [WIDTH-1:0] rdData,
  input  wire logic             rdReady
);

  localparam int AW = $clog2(DEPTH);

  logic [AW:0] wrBin_q, wrBin_d, wrGray_q, wrGray_d;
  logic [AW:0] rdBin_q, rdBin_d, rdGray_q, rdGray_d;
  logic [AW:0] rgMeta_q, rgSync_q, wgMeta_q, wgSync_q;
  logic        rdValid_q, rdValid_d;
  logic        full, empty, push, fetch;

  // ---------------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------------
  assign full    = wrGray_q == {~rgSync_q[AW:AW-1], rgSync_q[AW-2:0]};
  assign wrReady = !full;
  assign push    = wrValid && !full;

  always_comb begin
    wrBin_d  = push ? wrBin_q + 1'b1 : wrBin_q;
    wrGray_d = wrBin_d ^ (wrBin_d >> 1);
  end

  always_ff @(posedge wrClk) begin
    if (!wrRstn) begin
      wrBin_q  <= '0;
      wrGray_q <= '0;
      rgMeta_q <= '0;
      rgSync_q <= '0;
    end else begin
      wrBin_q  <= wrBin_d;
      wrGray_q <= wrGray_d;
      rgMeta_q <= rdGray_q;
      rgSync_q <= rgMeta_q;
    end
  end

  // ---------------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------------
  assign empty   = rdGray_q == wgSync_q;
  assign fetch   = !empty && (!rdValid_q || rdReady);
  assign rdValid = rdValid_q;

  always_comb begin
    rdBin_d   = fetch ? rdBin_q + 1'b1 : rdBin_q;
    rdGray_d  = rdBin_d ^ (rdBin_d >> 1);
    rdValid_d = fetch ? 1'b1 : (rdReady ? 1'b0 : rdValid_q);
  end

  always_ff @(posedge rdClk) begin
    if (!rdRstn) begin
      rdBin_q   <= '0;
      rdGray_q  <= '0;
      wgMeta_q  <= '0;
      wgSync_q  <= '0;
      rdValid_q <= 1'b0;
    end else begin
      rdBin_q   <= rdBin_d;
      rdGray_q  <= rdGray_d;
      wgMeta_q  <= wrGray_q;
      wgSync_q  <= wgMeta_q;
      rdValid_q <= rdValid_d;
    end
  end

  armap_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) uMem (
    .wrClk    (wrClk),
    .wrEn     (push),
    .wrAddr   (wrBin_q[AW-1:0]),
    .wrData   (wrData),
    .rdClk    (rdClk),
    .rdEn     (fetch),
    .rdAddr   (rdBin_q[AW-1:0]),
    .rdData_q (rdData)
  );

endmodule // armap_fifo

/* rtl/armap_rx_slot_mapper.sv */
// Purpose: Receive slot mapper of the primary audio serial port
// Assumes: Link pins change with bclk; config is static while frames run
// Notes:   Channels 1 and 2 feed the converter through a 16-word FIFO
//
// What this block does
// R01: Channel n takes data from secondary input when pin-select bit n-1 is set.
// R02: Channel 1 config bit 5 enables channel 1 to converter channel 1; resets on.
// R03: Channel 2 config bit 5 enables channel 2 to converter channel 2; resets on.
// R04: In TDM the 5-bit slot field is a direct slot index 0 to 31.
// R05: In I2S or left-justified, codes 0-15 are left slots, 16-31 right slots.
// R06: Reset values: channel 1 config 0x20, channel 2 config 0x21.
// R07: Software writes reserved bits 7..6 as zero; they read back as zero.
// R08: Pin-select register resets to zero, all channels on the primary input.
// R09: A disabled channel never updates its converter sample output.

`timescale 1ns/100ps

module armap_rx_slot_mapper
  import armap_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  output logic      [7:0]        regRdData_q,
  input  wire logic [1:0]        audioFormat,
  input  wire logic              bclk,
  input  wire logic              fsync,
  input  wire logic              primaryData,
  input  wire logic              secondaryData,
  output logic                   rxOverrun_q,
  input  wire logic              dacReady,
  output logic      [WORD_W-1:0] dacCh1Data_q,
  output logic                   dacCh1Valid_q,
  output logic      [WORD_W-1:0] dacCh2Data_q,
  output logic                   dacCh2Valid_q
);

  // ---------------------------------------------------------------------
  // Register file (system clock)
  // ---------------------------------------------------------------------
  logic [PIN_SEL_W-1:0] pinSel_q, pinSel_d;
  logic [CFG_W-1:0]     chCfg_q [NUM_CH];
  logic [CFG_W-1:0]     chCfg_d [NUM_CH];
  logic [1:0]           fmt_q, fmt_d;
  logic [7:0]           rdData_d;
  logic [7:0]           chRst   [NUM_CH];
  logic [7:0]           chAddr  [NUM_CH];

  assign chRst[0]  = RST_CH1_CFG;
  assign chRst[1]  = RST_CH2_CFG;
  assign chAddr[0] = ADDR_CH1_CFG;
  assign chAddr[1] = ADDR_CH2_CFG;

  always_comb begin
    pinSel_d = pinSel_q;
    fmt_d    = audioFormat;
    rdData_d = regRdData_q;
    for (int i = 0; i < NUM_CH; i++) begin
      chCfg_d[i] = chCfg_q[i];
      // Reserved bits are not stored at all, so they read back zero
      if (regWrEn && regAddr == chAddr[i]) begin
        chCfg_d[i] = regWrData[CFG_W-1:0]; // R07
      end
    end
    if (regWrEn && regAddr == ADDR_PIN_SEL) begin
      pinSel_d = regWrData;
    end
    if (regRdEn) begin
      unique case (regAddr)
        ADDR_PIN_SEL: rdData_d = pinSel_q;
        ADDR_CH1_CFG: rdData_d = {CFG_RSVD_ZERO[7:CFG_W], chCfg_q[0]}; // R07
        ADDR_CH2_CFG: rdData_d = {CFG_RSVD_ZERO[7:CFG_W], chCfg_q[1]}; // R07
        default:      rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinSel_q    <= RST_PIN_SEL; // R08
      fmt_q       <= FMT_TDM;
      regRdData_q <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        chCfg_q[i] <= chRst[i][CFG_W-1:0]; // R06
      end
    end else begin
      pinSel_q    <= pinSel_d;
      fmt_q       <= fmt_d;
      regRdData_q <= rdData_d;
      for (int i = 0; i < NUM_CH; i++) begin
        chCfg_q[i] <= chCfg_d[i];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Crossing into the bit clock
  // ---------------------------------------------------------------------
  // Per-bit synchronisers: safe only because config is held static
  // while frames run; a change mid-frame may mix old and new fields.
  localparam int XW = NUM_CH + 2 * CFG_W + 2;

  logic [XW-1:0] cfgMeta_q, cfgSync_q, cfgSrc;
  logic [1:0]    bRst_q;
  logic          bRstn;

  assign cfgSrc = {fmt_q, chCfg_q[1], chCfg_q[0], pinSel_q[NUM_CH-1:0]};
  assign bRstn  = bRst_q[1];

  always_ff @(posedge bclk) begin
    bRst_q    <= {bRst_q[0], rstn};
    cfgMeta_q <= cfgSrc;
    cfgSync_q <= cfgMeta_q;
  end

  logic [NUM_CH-1:0] bPinSel;
  logic [CFG_W-1:0]  bCfg [NUM_CH];
  logic [1:0]        bFmt;

  assign bPinSel = cfgSync_q[NUM_CH-1:0];
  assign bCfg[0] = cfgSync_q[NUM_CH +: CFG_W];
  assign bCfg[1] = cfgSync_q[NUM_CH + CFG_W +: CFG_W];
  assign bFmt    = cfgSync_q[XW-1 -: 2];

  // ---------------------------------------------------------------------
  // Frame tracking on the bit clock
  // ---------------------------------------------------------------------
  logic              fs_q, fsPrev_q, pd_q, sd_q, edgeDly_q, edgeDly_d;
  logic              half_q, half_d;
  armap_rx_e         rxState_q, rxState_d;
  logic [POS_W-1:0]  pos_q, pos_d, posCur;
  logic [WORD_W-2:0] shP_q, shP_d, shS_q, shS_d;
  logic              fsEdge, startNow, wordDone;
  logic [4:0]        slotCode;
  logic              slotOk;

  // TDM frames open on the rising fsync edge; two-slot formats on either
  assign fsEdge   = (bFmt == FMT_TDM) ? (fs_q && !fsPrev_q) : (fs_q != fsPrev_q);
  // Left-justified puts the MSB on the edge, the others one bit later
  assign startNow = (bFmt == FMT_LEFT_JUST) ? fsEdge : edgeDly_q;
  assign posCur   = startNow ? '0 : pos_q;
  assign wordDone = (startNow || rxState_q == RX_RUN) && posCur[4:0] == LAST_BIT;

  always_comb begin
    if (bFmt == FMT_TDM) begin
      slotCode = posCur[9:5]; // R04
      slotOk   = 1'b1;
    end else begin
      slotCode = {half_d, posCur[8:5]}; // R05
      slotOk   = !posCur[9];
    end
  end

  always_comb begin
    edgeDly_d = fsEdge;
    shP_d     = {shP_q[WORD_W-3:0], pd_q};
    shS_d     = {shS_q[WORD_W-3:0], sd_q};
    half_d    = half_q;
    pos_d     = pos_q;
    rxState_d = rxState_q;
    if (startNow) begin
      // Right half: fsync high for I2S, low for left-justified
      // Left-justified starts on the edge itself, so the new level is fs_q
      half_d    = (bFmt == FMT_I2S) ? fsPrev_q : !fs_q;
      pos_d     = 10'h001;
      rxState_d = RX_RUN;
    end else if (rxState_q == RX_RUN) begin
      pos_d = pos_q + 1'b1;
      if (pos_q == POS_LAST) begin
        rxState_d = RX_HUNT;
      end
    end
  end

  always_ff @(posedge bclk) begin
    if (!bRstn) begin
      fs_q      <= 1'b0;
      fsPrev_q  <= 1'b0;
      pd_q      <= 1'b0;
      sd_q      <= 1'b0;
      edgeDly_q <= 1'b0;
      half_q    <= 1'b0;
      pos_q     <= '0;
      rxState_q <= RX_HUNT;
      shP_q     <= '0;
      shS_q     <= '0;
    end else begin
      fs_q      <= fsync;
      fsPrev_q  <= fs_q;
      pd_q      <= primaryData;
      sd_q      <= secondaryData;
      edgeDly_q <= edgeDly_d;
      half_q    <= half_d;
      pos_q     <= pos_d;
      rxState_q <= rxState_d;
      shP_q     <= shP_d;
      shS_q     <= shS_d;
    end
  end

  // ---------------------------------------------------------------------
  // Slot match per channel
  // ---------------------------------------------------------------------
  logic [NUM_CH-1:0] hit;
  logic [WORD_W-1:0] chWord [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : gCh
    assign chWord[c] = bPinSel[c] ? {shS_q, sd_q} : {shP_q, pd_q}; // R01
    assign hit[c]    = wordDone && slotOk && bCfg[c][CFG_EN_BIT] // R02 R03 R09
                       && slotCode == bCfg[c][CFG_SLOT_MSB:0];
  end

  // ---------------------------------------------------------------------
  // Push stage into the FIFO
  // ---------------------------------------------------------------------
  // Both channels may share a slot; channel 2 then waits one bit clock.
  logic              pushV_q, pushV_d, pend_q, pend_d, ovr_d, wrReady;
  logic [FIFO_W-1:0] push_q, push_d, pendW_q, pendW_d;

  always_comb begin
    pushV_d = 1'b0;
    push_d  = push_q;
    pend_d  = pend_q;
    pendW_d = pendW_q;
    ovr_d   = pushV_q && !wrReady;
    if (hit[0]) begin
      pushV_d = 1'b1;
      push_d  = {1'b0, chWord[0]};
      pend_d  = hit[1];
      pendW_d = {1'b1, chWord[1]};
    end else if (hit[1]) begin
      pushV_d = 1'b1;
      push_d  = {1'b1, chWord[1]};
    end else if (pend_q) begin
      pushV_d = 1'b1;
      push_d  = pendW_q;
      pend_d  = 1'b0;
    end
  end

  always_ff @(posedge bclk) begin
    if (!bRstn) begin
      pushV_q     <= 1'b0;
      push_q      <= '0;
      pend_q      <= 1'b0;
      pendW_q     <= '0;
      rxOverrun_q <= 1'b0;
    end else begin
      pushV_q     <= pushV_d;
      push_q      <= push_d;
      pend_q      <= pend_d;
      pendW_q     <= pendW_d;
      rxOverrun_q <= ovr_d;
    end
  end

  logic              fifoValid;
  logic [FIFO_W-1:0] fifoData;

  armap_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .wrClk   (bclk),
    .wrRstn  (bRstn),
    .wrValid (pushV_q),
    .wrData  (push_q),
    .wrReady (wrReady),
    .rdClk   (clk),
    .rdRstn  (rstn),
    .rdValid (fifoValid),
    .rdData  (fifoData),
    .rdReady (dacReady)
  );

  // ---------------------------------------------------------------------
  // Converter outputs (system clock)
  // ---------------------------------------------------------------------
  // Outputs hold their last sample; only a popped word updates them.
  logic [WORD_W-1:0] d1_d, d2_d;
  logic              v1_d, v2_d, pop;

  assign pop = fifoValid && dacReady;

  always_comb begin
    d1_d = dacCh1Data_q;
    d2_d = dacCh2Data_q;
    v1_d = pop && !fifoData[WORD_W];
    v2_d = pop && fifoData[WORD_W];
    if (v1_d) begin
      d1_d = fifoData[WORD_W-1:0]; // R09
    end
    if (v2_d) begin
      d2_d = fifoData[WORD_W-1:0]; // R09
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dacCh1Data_q  <= '0;
      dacCh2Data_q  <= '0;
      dacCh1Valid_q <= 1'b0;
      dacCh2Valid_q <= 1'b0;
    end else begin
      dacCh1Data_q  <= d1_d;
      dacCh2Data_q  <= d2_d;
      dacCh1Valid_q <= v1_d;
      dacCh2Valid_q <= v2_d;
    end
  end

endmodule // armap_rx_slot_mapper

/* verif/armap_rx_monitor.sv */
// Purpose: Port checks for the receive slot mapper
// Assumes: Bound onto armap_rx_slot_mapper
// Notes:   Shadow registers mirror the writes seen at the ports
`timescale 1ns/100ps
module armap_rx_monitor
  import armap_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [7:0]        regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic [7:0]        regRdData_q,
  input wire logic              bclk,
  input wire logic              rxOverrun_q,
  input wire logic              dacReady,
  input wire logic [WORD_W-1:0] dacCh1Data_q,
  input wire logic              dacCh1Valid_q,
  input wire logic [WORD_W-1:0] dacCh2Data_q,
  input wire logic              dacCh2Valid_q
);
  // ---------------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------------
  logic [7:0] pinSel_q, pinSel_d, ch1Cfg_q, ch1Cfg_d, ch2Cfg_q, ch2Cfg_d;
  always_comb begin
    pinSel_d = pinSel_q;
    ch1Cfg_d = ch1Cfg_q;
    ch2Cfg_d = ch2Cfg_q;
    if (regWrEn && regAddr == ADDR_PIN_SEL) pinSel_d = regWrData;
    if (regWrEn && regAddr == ADDR_CH1_CFG) ch1Cfg_d = {2'b00, regWrData[5:0]};
    if (regWrEn && regAddr == ADDR_CH2_CFG) ch2Cfg_d = {2'b00, regWrData[5:0]};
  end
  always_ff @(posedge clk) begin
    pinSel_q <= rstn ? pinSel_d : RST_PIN_SEL;
    ch1Cfg_q <= rstn ? ch1Cfg_d : RST_CH1_CFG;
    ch2Cfg_q <= rstn ? ch2Cfg_d : RST_CH2_CFG;
  end
  sequence s_rd(logic [7:0] a);
    regRdEn && regAddr == a;
  endsequence
  property p_pinRd;
    @(posedge clk) disable iff (!rstn) s_rd(ADDR_PIN_SEL) |=> regRdData_q == $past(pinSel_q);
  endproperty
  a_pinRd: assert property (p_pinRd) else $error("pin select readback wrong");
  property p_ch1Rd;
    @(posedge clk) disable iff (!rstn) s_rd(ADDR_CH1_CFG) |=> regRdData_q == $past(ch1Cfg_q);
  endproperty
  a_ch1Rd: assert property (p_ch1Rd) else $error("ch1 config readback wrong");
  property p_ch2Rd;
    @(posedge clk) disable iff (!rstn) s_rd(ADDR_CH2_CFG) |=> regRdData_q == $past(ch2Cfg_q);
  endproperty
  a_ch2Rd: assert property (p_ch2Rd) else $error("ch2 config readback wrong");
  property p_rsvd;
    @(posedge clk) disable iff (!rstn)
      (s_rd(ADDR_CH1_CFG) or s_rd(ADDR_CH2_CFG)) |=> regRdData_q[7:6] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_en1;
    @(posedge clk) disable iff (!rstn) dacCh1Valid_q |-> ch1Cfg_q[CFG_EN_BIT];
  endproperty
  a_en1: assert property (p_en1) else $error("ch1 sample while disabled");
  property p_en2;
    @(posedge clk) disable iff (!rstn) dacCh2Valid_q |-> ch2Cfg_q[CFG_EN_BIT];
  endproperty
  a_en2: assert property (p_en2) else $error("ch2 sample while disabled");
  property p_hold1;
    @(posedge clk) disable iff (!rstn) $changed(dacCh1Data_q) |-> dacCh1Valid_q;
  endproperty
  a_hold1: assert property (p_hold1) else $error("ch1 data moved without valid");
  property p_hold2;
    @(posedge clk) disable iff (!rstn) $changed(dacCh2Data_q) |-> dacCh2Valid_q;
  endproperty
  a_hold2: assert property (p_hold2) else $error("ch2 data moved without valid");
  property p_ready;
    @(posedge clk) disable iff (!rstn) (dacCh1Valid_q || dacCh2Valid_q) |-> $past(dacReady);
  endproperty
  a_ready: assert property (p_ready) else $error("sample sent while stalled");
  property p_ovr;
    @(posedge bclk) disable iff (!rstn) rxOverrun_q |=> !rxOverrun_q;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun longer than one bit clock");
endmodule // armap_rx_monitor

bind armap_rx_slot_mapper armap_rx_monitor armap_rx_monitor_i (
  .clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q, .bclk,
  .rxOverrun_q, .dacReady, .dacCh1Data_q, .dacCh1Valid_q, .dacCh2Data_q, .dacCh2Valid_q
);

/* verif/armap_host_model.sv */
// Purpose: Host processor model driving receive frames
// Assumes: Bit clock runs only during frames and idle bursts
// Notes:   Secondary pin carries the inverse of the primary bit
`timescale 1ns/100ps
module armap_host_model
  import armap_pkg::*;
(
  output logic bclk,
  output logic fsync,
  output logic primaryData,
  output logic secondaryData
);
  // ---------------------------------------------------------------------
  // Bit clock and frame drive
  // ---------------------------------------------------------------------
  logic runClk = 1'b0;
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    primaryData = 1'b0;
    secondaryData = 1'b1;
    #1.3;
    forever begin
      #3;
      bclk = runClk ? ~bclk : 1'b0;
    end
  end
  // Changes on the falling edge, sampled on the rising one
  task bitOut(input logic fs, input logic p);
    @(negedge bclk);
    fsync = fs;
    primaryData = p;
    secondaryData = ~p;
  endtask
  // Toggling data stands for a released line
  task idle(input int n);
    runClk = 1'b1;
    repeat (n) bitOut(fsync, ~primaryData);
    @(negedge bclk);
    runClk = 1'b0;
  endtask
  task wordOut(input logic fs, input int code);
    logic [31:0] v;
    v = {16'hC3A5, 8'(code), 8'h96};
    for (int b = 31; b >= 0; b--) bitOut(fs, v[b]);
  endtask
  task driveFrame(input logic [1:0] fmt, input int n);
    runClk = 1'b1;
    repeat (8) bitOut(fsync, ~primaryData);
    if (fmt == FMT_TDM) begin
      bitOut(1'b1, 1'b0);
      for (int s = 0; s < n; s++) wordOut(1'b0, s);
    end else if (fmt == FMT_I2S) begin
      bitOut(1'b1, 1'b0);
      bitOut(1'b0, 1'b0);
      for (int s = 0; s < n; s++) wordOut(1'b0, s);
      bitOut(1'b1, 1'b0);
      for (int s = 0; s < n; s++) wordOut(1'b1, 16 + s);
    end else begin
      bitOut(1'b0, 1'b0);
      for (int s = 0; s < n; s++) wordOut(1'b1, s);
      for (int s = 0; s < n; s++) wordOut(1'b0, 16 + s);
    end
    idle(8);
  endtask
endmodule // armap_host_model

/* verif/armap_rx_slot_mapper_tb.sv */
// Purpose: Self-checking bench for the receive slot mapper
// Assumes: Config changes only while the link is idle
// Notes:   Expected words follow the host model's pattern
`timescale 1ns/100ps
module armap_rx_slot_mapper_tb
  import armap_pkg::*;
;
  logic              clk, rstn, regWrEn, regRdEn, dacReady, rxOverrun_q;
  logic              bclk, fsync, primaryData, secondaryData, dacCh1Valid_q, dacCh2Valid_q;
  logic [1:0]        audioFormat;
  logic [7:0]        regAddr, regWrData, regRdData_q, d;
  logic [WORD_W-1:0] dacCh1Data_q, dacCh2Data_q;
  logic [7:0]        ra [4] = '{ADDR_PIN_SEL, ADDR_CH1_CFG, ADDR_CH2_CFG, 8'h30};
  logic [7:0]        rv [4] = '{RST_PIN_SEL, RST_CH1_CFG, RST_CH2_CFG, 8'h00};
  int                errCount = 0, checks = 0, n1 = 0, n2 = 0, ovCnt = 0, cyc = 0;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  armap_rx_slot_mapper armap_rx_slot_mapper_i (
    .clk(clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
    .audioFormat(audioFormat), .bclk(bclk), .fsync(fsync),
    .primaryData(primaryData), .secondaryData(secondaryData),
    .rxOverrun_q(rxOverrun_q), .dacReady(dacReady),
    .dacCh1Data_q(dacCh1Data_q), .dacCh1Valid_q(dacCh1Valid_q),
    .dacCh2Data_q(dacCh2Data_q), .dacCh2Valid_q(dacCh2Valid_q)
  );
  armap_host_model armap_host_model_i (
    .bclk(bclk), .fsync(fsync), .primaryData(primaryData), .secondaryData(secondaryData)
  );

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task tallyAndFinish;
    $display("Mismatches %0d, comparisons %0d", errCount, checks);
    if (errCount == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (dacCh1Valid_q === 1'b1) n1++;
    if (dacCh2Valid_q === 1'b1) n2++;
    if (cyc == 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  always @(posedge bclk) if (rxOverrun_q === 1'b1) ovCnt++;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] w(input int code, input logic sec);
    logic [31:0] v;
    v = {16'hC3A5, 8'(code), 8'h96};
    return sec ? ~v : v;
  endfunction
  task regWr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk) regWrEn <= 1'b0;
  endtask
  task regRd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk) regRdEn <= 1'b0;
    @(posedge clk) #1 v = regRdData_q;
  endtask
  task waitWords(input int k);
    for (int i = 0; i < 400 && n1 + n2 < k; i++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task runCase(input logic [1:0] f, input logic [7:0] p, c1, c2, input int n, k1, k2,
               input logic [31:0] x1, x2);
    @(posedge clk) audioFormat <= f;
    regWr(ADDR_PIN_SEL, p);
    regWr(ADDR_CH1_CFG, c1);
    regWr(ADDR_CH2_CFG, c2);
    n1 = 0;
    n2 = 0;
    armap_host_model_i.driveFrame(f, n);
    waitWords(k1 + k2);
    chk(32'(n1), 32'(k1));
    chk(32'(n2), 32'(k2));
    chk(dacCh1Data_q, x1);
    chk(dacCh2Data_q, x2);
  endtask

  initial begin
    rstn = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    audioFormat = FMT_TDM;
    dacReady = 1'b1;
    fork
      armap_host_model_i.idle(4);
      repeat (5) @(posedge clk);
    join
    @(posedge clk) rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      regRd(ra[i], d);
      chk(32'(d), 32'(rv[i]));
    end
    regWr(ADDR_CH1_CFG, 8'h3F);
    regRd(ADDR_CH1_CFG, d);
    chk(32'(d), 32'h0000_003F);
    regWr(ADDR_PIN_SEL, 8'hFE);
    regRd(ADDR_PIN_SEL, d);
    chk(32'(d), 32'h0000_00FE);
    runCase(FMT_TDM, 8'h00, 8'h20, 8'h21, 2, 1, 1, w(0, 0), w(1, 0));
    runCase(FMT_TDM, 8'h01, 8'h3F, 8'h25, 32, 1, 1, w(31, 1), w(5, 0));
    runCase(FMT_I2S, 8'h02, 8'h2F, 8'h30, 16, 1, 1, w(15, 0), w(16, 1));
    runCase(FMT_LEFT_JUST, 8'h01, 8'h31, 8'h23, 4, 1, 1, w(17, 1), w(3, 0));
    runCase(FMT_TDM, 8'h00, 8'h00, 8'h22, 3, 0, 1, w(17, 1), w(2, 0));
    runCase(FMT_TDM, 8'h03, 8'h24, 8'h04, 5, 1, 0, w(4, 1), w(2, 0));
    runCase(FMT_TDM, 8'h00, 8'h26, 8'h26, 7, 1, 1, w(6, 0), w(6, 0));
    runCase(FMT_TDM, 8'h00, 8'h20, 8'h21, 2, 1, 1, w(0, 0), w(1, 0));
    // Stalled converter: 18 words offered, 16 stored plus one in the read register
    @(posedge clk) dacReady <= 1'b0;
    n1 = 0;
    n2 = 0;
    ovCnt = 0;
    repeat (9) armap_host_model_i.driveFrame(FMT_TDM, 2);
    chk(32'(n1 + n2), 32'h0000_0000);
    chk(32'(ovCnt), 32'h0000_0001);
    @(posedge clk) dacReady <= 1'b1;
    waitWords(17);
    chk(32'(n1 + n2), 32'h0000_0011);
    chk(dacCh1Data_q, w(0, 0));
    chk(dacCh2Data_q, w(1, 0));
    tallyAndFinish();
  end
endmodule // armap_rx_slot_mapper_tb
